// File: sspc_dev.sv
// device end: pin sampling, byte shifting, pause and io mode tracking
`default_nettype none
module sspc_dev
   import sspc_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   sspc_if.dev             bus,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic       i_tx_en,
   input  wire logic       i_wr_busy,
   output logic      [7:0] o_rx_byte,
   output logic            o_rx_valid,
   output logic            o_cmd_first,
   output logic            o_tx_take,
   output logic            o_selected,
   output logic            o_standby,
   output logic            o_paused,
   output var sspc_mode_t  o_mode
);
   logic       cs_s1_reg;
   logic       cs_s2_reg;
   logic       sck_s1_reg;
   logic       sck_s2_reg;
   logic       sck_d_reg;
   logic [3:0] sio_s1_reg;
   logic [3:0] sio_s2_reg;
   sspc_mode_t mode_reg;
   sspc_mode_t mode_next_reg;
   logic       begun_reg;
   logic       paused_reg;
   logic       drive_reg;
   logic       first_reg;
   logic       cmd_first_reg;
   logic [3:0] rx_cnt_reg;
   logic [3:0] tx_cnt_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] tx_sh_reg;
   logic [7:0] rx_byte_reg;
   logic       rx_valid_reg;
   logic       tx_take_reg;

   logic       selected;
   logic       hold_low;
   logic       rise;
   logic       fall;
   logic       pause_go;
   logic       edge_ok;
   logic [3:0] steps;
   logic [3:0] in_bits;
   logic [3:0] out_bits;
   logic [7:0] rx_sh_next;
   logic [3:0] rx_cnt_next;
   logic [3:0] tx_cnt_next;

   // two-flop synchronisers for all pins
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cs_s1_reg  <= 1'b1;
         cs_s2_reg  <= 1'b1;
         sck_s1_reg <= 1'b0;
         sck_s2_reg <= 1'b0;
         sck_d_reg  <= 1'b0;
         sio_s1_reg <= SSPC_OE_OFF;
         sio_s2_reg <= SSPC_OE_OFF;
      end else begin
         cs_s1_reg  <= bus.cs_n;
         cs_s2_reg  <= cs_s1_reg;
         sck_s1_reg <= bus.sck;
         sck_s2_reg <= sck_s1_reg;
         sck_d_reg  <= sck_s2_reg;
         sio_s1_reg <= bus.sio;
         sio_s2_reg <= sio_s1_reg;
      end
   end

   assign selected = !cs_s2_reg;
   assign rise     = sck_s2_reg && !sck_d_reg;
   assign fall     = !sck_s2_reg && sck_d_reg;
   assign hold_low = !sio_s2_reg[3] && (mode_reg != SSPC_MODE_QUAD);
   // pause starts now if clock low, else at the coming fall
   assign pause_go = selected && begun_reg && hold_low && !paused_reg &&
                     (!sck_s2_reg || fall);
   assign edge_ok  = selected && !paused_reg && !pause_go;
   assign steps    = sspc_steps(mode_reg);
   assign in_bits  = (mode_reg == SSPC_MODE_SINGLE) ? {3'h0, sio_s2_reg[0]} : sio_s2_reg;
   assign rx_sh_next  = sspc_shift_in(rx_sh_reg, in_bits, mode_reg);
   assign rx_cnt_next = rx_cnt_reg + 4'h1;
   assign tx_cnt_next = (tx_cnt_reg + 4'h1 == steps) ? SSPC_CNT_RST : tx_cnt_reg + 4'h1;

   // pause state
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         paused_reg <= 1'b0;
      end else if (!selected) begin
         paused_reg <= 1'b0;
      end else if (pause_go) begin
         paused_reg <= 1'b1;
      end else if (paused_reg && !hold_low && !sck_s2_reg) begin
         paused_reg <= 1'b0;
      end
   end

   // sequence progress, kept across a pause
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         begun_reg <= 1'b0;
      end else if (!selected) begin
         begun_reg <= 1'b0;
      end else if (rise && edge_ok) begin
         begun_reg <= 1'b1;
      end
   end

   // receive shifter
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_sh_reg    <= SSPC_BYTE_RST;
         rx_cnt_reg   <= SSPC_CNT_RST;
         rx_byte_reg  <= SSPC_BYTE_RST;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         if (!selected) begin
            rx_cnt_reg <= SSPC_CNT_RST;
         end else if (rise && edge_ok) begin
            rx_sh_reg <= rx_sh_next;
            if (rx_cnt_next == steps) begin
               rx_cnt_reg   <= SSPC_CNT_RST;
               rx_byte_reg  <= rx_sh_next;
               rx_valid_reg <= 1'b1;
            end else begin
               rx_cnt_reg <= rx_cnt_next;
            end
         end
      end
   end

   // first byte of a frame is the command
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_reg     <= 1'b1;
         cmd_first_reg <= 1'b0;
      end else if (!selected) begin
         first_reg     <= 1'b1;
         cmd_first_reg <= 1'b0;
      end else if (rise && edge_ok && rx_cnt_next == steps) begin
         first_reg     <= 1'b0;
         cmd_first_reg <= first_reg;
      end
   end

   // io mode: command decoded, applied at deselect
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_reg      <= SSPC_MODE_SINGLE;
         mode_next_reg <= SSPC_MODE_SINGLE;
      end else if (!selected) begin
         mode_reg <= mode_next_reg;
      end else if (rise && edge_ok && rx_cnt_next == steps && first_reg) begin
         mode_next_reg <= sspc_cmd_mode(rx_sh_next, mode_reg);
      end
   end

   // transmit shifter, moves on the falling clock
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_sh_reg   <= SSPC_BYTE_RST;
         tx_cnt_reg  <= SSPC_TX_CNT_START;
         tx_take_reg <= 1'b0;
      end else begin
         tx_take_reg <= 1'b0;
         if (!selected) begin
            tx_cnt_reg <= SSPC_TX_CNT_START;
         end else if (fall && edge_ok) begin
            tx_cnt_reg <= tx_cnt_next;
            if (tx_cnt_reg == SSPC_CNT_RST) begin
               tx_sh_reg   <= i_tx_byte;
               tx_take_reg <= 1'b1;
            end else begin
               tx_sh_reg <= sspc_shift_out(tx_sh_reg, mode_reg);
            end
         end
      end
   end

   // output phase opens only at a falling clock
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         drive_reg <= 1'b0;
      end else if (!selected) begin
         drive_reg <= 1'b0;
      end else if (fall && edge_ok) begin
         drive_reg <= i_tx_en;
      end
   end

   assign out_bits = sspc_top(tx_sh_reg, mode_reg);

   // pin drivers; enables are active low
   always_comb begin
      bus.d_sio_o    = 4'h0;
      bus.d_sio_oe_n = SSPC_OE_OFF;
      case (mode_reg)
         SSPC_MODE_SINGLE: begin
            bus.d_sio_o    = {2'h0, out_bits[0], 1'h0};
            bus.d_sio_oe_n = SSPC_OE_DEV_SGL;
         end
         SSPC_MODE_DUAL: begin
            bus.d_sio_o    = out_bits;
            bus.d_sio_oe_n = SSPC_OE_DEV_DUAL;
         end
         SSPC_MODE_QUAD: begin
            bus.d_sio_o    = out_bits;
            bus.d_sio_oe_n = SSPC_OE_ALL;
         end
         default: begin
            bus.d_sio_o    = 4'h0;
            bus.d_sio_oe_n = SSPC_OE_OFF;
         end
      endcase
      if (!selected || !drive_reg) begin
         bus.d_sio_oe_n = SSPC_OE_OFF;
      end
      if (paused_reg || hold_low) begin
         bus.d_sio_oe_n = SSPC_OE_OFF;
      end
   end

   assign o_rx_byte   = rx_byte_reg;
   assign o_rx_valid  = rx_valid_reg;
   assign o_cmd_first = cmd_first_reg;
   assign o_tx_take   = tx_take_reg;
   assign o_selected  = selected;
   assign o_standby   = cs_s2_reg && !i_wr_busy;
   assign o_paused    = paused_reg;
   assign o_mode      = mode_reg;
endmodule
`default_nettype wire

// File: sspc_host.sv
// host end: serial clock generator, framing, pause and io mode tracking
`default_nettype none
module sspc_host
   import sspc_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   sspc_if.host            bus,
   input  wire logic       i_req,
   input  wire logic [7:0] i_tx_byte,
   input  wire logic       i_read,
   input  wire logic       i_last,
   input  wire logic       i_pause,
   output logic            o_ready,
   output logic      [7:0] o_rx_byte,
   output logic            o_rx_valid,
   output logic            o_paused,
   output var sspc_mode_t  o_mode
);
   typedef enum logic [2:0] {
      ST_INIT  = 3'h0,
      ST_IDLE  = 3'h1,
      ST_LOW   = 3'h2,
      ST_HIGH  = 3'h3,
      ST_GAP   = 3'h4,
      ST_PAUSE = 3'h5,
      ST_END   = 3'h6
   } sspc_hst_t;

   sspc_hst_t  state_reg;
   logic [3:0] div_reg;
   logic [3:0] cnt_reg;
   logic       cs_n_reg;
   logic       sck_reg;
   logic       hold_n_reg;
   logic       read_reg;
   logic       last_reg;
   logic       first_reg;
   logic       begun_reg;
   logic [7:0] tx_sh_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] rx_byte_reg;
   logic       rx_valid_reg;
   sspc_mode_t mode_reg;
   sspc_mode_t mode_next_reg;
   logic [3:0] sio_s1_reg;
   logic [3:0] sio_s2_reg;

   logic       half_done;
   logic       take;
   logic [3:0] in_bits;
   logic [3:0] out_bits;
   logic [7:0] rx_sh_next;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sio_s1_reg <= SSPC_OE_OFF;
         sio_s2_reg <= SSPC_OE_OFF;
      end else begin
         sio_s1_reg <= bus.sio;
         sio_s2_reg <= sio_s1_reg;
      end
   end

   assign half_done  = (div_reg == SSPC_HALF_LAST);
   assign o_ready    = (state_reg == ST_IDLE) || (state_reg == ST_GAP);
   assign take       = o_ready && i_req;
   assign in_bits    = (mode_reg == SSPC_MODE_SINGLE) ? {3'h0, sio_s2_reg[1]} : sio_s2_reg;
   assign rx_sh_next = sspc_shift_in(rx_sh_reg, in_bits, mode_reg);
   assign out_bits   = sspc_top(tx_sh_reg, mode_reg);

   // half-period divider
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_reg <= SSPC_CNT_RST;
      end else if (half_done || take || state_reg == ST_PAUSE) begin
         div_reg <= SSPC_CNT_RST;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // framing state machine
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg  <= ST_INIT;
         cs_n_reg   <= 1'b0;
         sck_reg    <= 1'b0;
         hold_n_reg <= 1'b1;
         cnt_reg    <= SSPC_CNT_RST;
         begun_reg  <= 1'b0;
      end else begin
         case (state_reg)
            ST_INIT: begin
               if (half_done) begin
                  cs_n_reg  <= 1'b1;
                  state_reg <= ST_END;
               end
            end
            ST_IDLE, ST_GAP: begin
               if (take) begin
                  cs_n_reg  <= 1'b0;
                  cnt_reg   <= SSPC_CNT_RST;
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_done) begin
                  if (i_pause && begun_reg && mode_reg != SSPC_MODE_QUAD) begin
                     hold_n_reg <= 1'b0;
                     state_reg  <= ST_PAUSE;
                  end else begin
                     sck_reg   <= 1'b1;
                     begun_reg <= 1'b1;
                     state_reg <= ST_HIGH;
                  end
               end
            end
            ST_PAUSE: begin
               if (!i_pause) begin
                  hold_n_reg <= 1'b1;
                  state_reg  <= ST_LOW;
               end
            end
            ST_HIGH: begin
               if (half_done) begin
                  sck_reg <= 1'b0;
                  if (cnt_reg + 4'h1 == sspc_steps(mode_reg)) begin
                     cnt_reg   <= SSPC_CNT_RST;
                     state_reg <= last_reg ? ST_END : ST_GAP;
                  end else begin
                     cnt_reg   <= cnt_reg + 4'h1;
                     state_reg <= ST_LOW;
                  end
               end
            end
            ST_END: begin
               cs_n_reg  <= 1'b1;
               begun_reg <= 1'b0;
               if (half_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               cs_n_reg  <= 1'b1;
            end
         endcase
      end
   end

   // byte request capture and transmit shifting
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_sh_reg <= SSPC_BYTE_RST;
         read_reg  <= 1'b0;
         last_reg  <= 1'b0;
      end else if (take) begin
         tx_sh_reg <= i_tx_byte;
         read_reg  <= i_read;
         last_reg  <= i_last;
      end else if (state_reg == ST_HIGH && half_done) begin
         tx_sh_reg <= sspc_shift_out(tx_sh_reg, mode_reg);
      end
   end

   // receive sampling just before each falling edge
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rx_sh_reg    <= SSPC_BYTE_RST;
         rx_byte_reg  <= SSPC_BYTE_RST;
         rx_valid_reg <= 1'b0;
      end else begin
         rx_valid_reg <= 1'b0;
         if (state_reg == ST_HIGH && half_done) begin
            rx_sh_reg <= rx_sh_next;
            if (cnt_reg + 4'h1 == sspc_steps(mode_reg) && read_reg) begin
               rx_byte_reg  <= rx_sh_next;
               rx_valid_reg <= 1'b1;
            end
         end
      end
   end

   // io mode follows the command the host sent
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_reg     <= 1'b1;
         mode_reg      <= SSPC_MODE_SINGLE;
         mode_next_reg <= SSPC_MODE_SINGLE;
      end else if (state_reg == ST_END) begin
         first_reg <= 1'b1;
         mode_reg  <= mode_next_reg;
      end else if (take) begin
         first_reg <= 1'b0;
         if (first_reg && !i_read) begin
            mode_next_reg <= sspc_cmd_mode(i_tx_byte, mode_reg);
         end
      end
   end

   // pins; enables are active low, data lines released when reading in dual and quad modes
   always_comb begin
      bus.cs_n       = cs_n_reg;
      bus.sck        = sck_reg;
      bus.h_sio_o    = {hold_n_reg, 2'h0, out_bits[0]};
      bus.h_sio_oe_n = SSPC_OE_HST_SGL;
      case (mode_reg)
         SSPC_MODE_SINGLE: begin
            bus.h_sio_o    = {hold_n_reg, 2'h0, out_bits[0]};
            bus.h_sio_oe_n = SSPC_OE_HST_SGL;
         end
         SSPC_MODE_DUAL: begin
            bus.h_sio_o    = {hold_n_reg, 1'h0, out_bits[1:0]};
            bus.h_sio_oe_n = read_reg ? SSPC_OE_HST_DREAD : SSPC_OE_HST_DUAL;
         end
         SSPC_MODE_QUAD: begin
            bus.h_sio_o    = out_bits;
            bus.h_sio_oe_n = read_reg ? SSPC_OE_OFF : SSPC_OE_ALL;
         end
         default: begin
            bus.h_sio_o    = {hold_n_reg, 3'h0};
            bus.h_sio_oe_n = SSPC_OE_HST_DREAD;
         end
      endcase
      if (mode_reg == SSPC_MODE_QUAD && (cs_n_reg || state_reg == ST_GAP)) begin
         bus.h_sio_oe_n = SSPC_OE_OFF;
      end
   end

   assign o_rx_byte  = rx_byte_reg;
   assign o_rx_valid = rx_valid_reg;
   assign o_paused   = (state_reg == ST_PAUSE);
   assign o_mode     = mode_reg;
endmodule
`default_nettype wire

// File: sspc_if.sv
// pin bundle joining host and device, with wire resolution
`default_nettype none
interface sspc_if;
   logic       cs_n;
   logic       sck;
   logic [3:0] h_sio_o;
   logic [3:0] h_sio_oe_n;
   logic [3:0] d_sio_o;
   logic [3:0] d_sio_oe_n;
   logic [3:0] sio;

   // undriven lines pull high
   for (genvar i = 0; i < 4; i++) begin : g_line
      assign sio[i] = !h_sio_oe_n[i] ? h_sio_o[i] :
                      (!d_sio_oe_n[i] ? d_sio_o[i] : 1'b1);
   end

   modport dev  (input cs_n, input sck, input sio, output d_sio_o, output d_sio_oe_n);
   modport host (output cs_n, output sck, output h_sio_o, output h_sio_oe_n, input sio);
endinterface
`default_nettype wire

// File: sspc_monitor.sv
// concurrent checks on the pins joining host and device ends
`default_nettype none
module sspc_monitor
   import sspc_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       cs_n,
   input  wire logic       sck,
   input  wire logic [3:0] h_sio_o,
   input  wire logic [3:0] h_sio_oe_n,
   input  wire logic [3:0] d_sio_o,
   input  wire logic [3:0] d_sio_oe_n
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // high half of the serial clock, then back low
   sequence s_high_half;
      sck [*8] ##1 !sck;
   endsequence

   // select pulse after reset
   sequence s_select_pulse;
      !cs_n [*4] ##[1:12] cs_n;
   endsequence

   AST_SELECT_FIRST: assert property (!$past(i_rst_n) |-> s_select_pulse)
      else $error("no select pulse after reset");
   AST_SCK_HALF: assert property ($rose(sck) |-> s_high_half)
      else $error("serial clock high half not eight cycles");
   AST_HOST_DATA_LOW: assert property (
      !cs_n && $changed(h_sio_o & ~h_sio_oe_n & 4'h7) |-> !sck)
      else $error("host data moved while clock high");
   AST_CS_FLOAT: assert property (cs_n [*4] |-> d_sio_oe_n == SSPC_OE_OFF)
      else $error("device drives while deselected");
   AST_DEV_CHANGE_LOW: assert property (
      !cs_n && d_sio_oe_n != SSPC_OE_OFF && $changed(d_sio_o) |-> !sck && !$past(sck, 2))
      else $error("device data moved outside low half");
   AST_DEV_STABLE_HIGH: assert property ($rose(sck) |-> $stable(d_sio_o) [*8])
      else $error("device data moved during high half");
   AST_CS_EDGE: assert property ($changed(cs_n) |-> !sck && !$past(sck))
      else $error("select moved while clock high");
   AST_NO_FIGHT: assert property ((~h_sio_oe_n & ~d_sio_oe_n) == 4'h0)
      else $error("host and device drive one line");
endmodule
`default_nettype wire

// File: sspc_pkg.sv
// shared constants, types and helpers for both ends of the serial sram pins
// Notes on behaviour
// - select low enables; select high means standby
// - write cycle finishes before standby
// - output lines float while select is high
// - host pulses select low once after reset
// - inputs captured on rising serial clock
// - outputs change only after falling serial clock
// - pause high normally; low suspends, keeps progress
// - pause immediate if clock low, else at fall
// - host keeps select low throughout pause
// - paused: outputs float, clock and data ignored
// - host releases pause only while clock low
// - pause low floats outputs at once
// - two-line mode only after its command
// - four-line mode only after its command
// - decode 38h quad, 3bh dual, ffh single
// - all fields shifted msb first
// - wide mode kept until return command
// - pause only in single and two-line modes
`default_nettype none
package sspc_pkg;
   typedef enum logic [1:0] {
      SSPC_MODE_SINGLE = 2'h0,
      SSPC_MODE_DUAL   = 2'h1,
      SSPC_MODE_QUAD   = 2'h2
   } sspc_mode_t;

   localparam logic [7:0] SSPC_CMD_QUAD   = 8'h38;
   localparam logic [7:0] SSPC_CMD_DUAL   = 8'h3b;
   localparam logic [7:0] SSPC_CMD_SINGLE = 8'hff;

   localparam int         SSPC_MCLK_NS      = 50;
   localparam int         SSPC_SCK_HALF_NS  = 400;
   localparam int         SSPC_SCK_HALF_CYC =
      (SSPC_SCK_HALF_NS + SSPC_MCLK_NS - 1) / SSPC_MCLK_NS;
   localparam logic [3:0] SSPC_HALF_LAST    = 4'(SSPC_SCK_HALF_CYC - 1);

   localparam logic [3:0] SSPC_CNT_RST      = 4'h0;
   localparam logic [3:0] SSPC_TX_CNT_START = 4'h1;
   localparam logic [7:0] SSPC_BYTE_RST     = 8'h00;
   localparam logic [3:0] SSPC_OE_OFF       = 4'hf;
   localparam logic [3:0] SSPC_OE_DEV_SGL   = 4'hd;
   localparam logic [3:0] SSPC_OE_DEV_DUAL  = 4'hc;
   localparam logic [3:0] SSPC_OE_ALL       = 4'h0;
   localparam logic [3:0] SSPC_OE_HST_SGL   = 4'h6;
   localparam logic [3:0] SSPC_OE_HST_DUAL  = 4'h4;
   localparam logic [3:0] SSPC_OE_HST_DREAD = 4'h7;

   // clock edges per byte
   function automatic logic [3:0] sspc_steps(input sspc_mode_t m);
      case (m)
         SSPC_MODE_DUAL: sspc_steps = 4'h4;
         SSPC_MODE_QUAD: sspc_steps = 4'h2;
         default:        sspc_steps = 4'h8;
      endcase
   endfunction

   // shift new bits in at the bottom, msb arrives first
   function automatic logic [7:0] sspc_shift_in(input logic [7:0] sh, input logic [3:0] d,
                                                input sspc_mode_t m);
      case (m)
         SSPC_MODE_DUAL: sspc_shift_in = {sh[5:0], d[1:0]};
         SSPC_MODE_QUAD: sspc_shift_in = {sh[3:0], d[3:0]};
         default:        sspc_shift_in = {sh[6:0], d[0]};
      endcase
   endfunction

   function automatic logic [7:0] sspc_shift_out(input logic [7:0] sh, input sspc_mode_t m);
      case (m)
         SSPC_MODE_DUAL: sspc_shift_out = {sh[5:0], 2'h0};
         SSPC_MODE_QUAD: sspc_shift_out = {sh[3:0], 4'h0};
         default:        sspc_shift_out = {sh[6:0], 1'h0};
      endcase
   endfunction

   // top bits of a shift register, aligned to bit 0
   function automatic logic [3:0] sspc_top(input logic [7:0] sh, input sspc_mode_t m);
      case (m)
         SSPC_MODE_DUAL: sspc_top = {2'h0, sh[7:6]};
         SSPC_MODE_QUAD: sspc_top = sh[7:4];
         default:        sspc_top = {3'h0, sh[7]};
      endcase
   endfunction

   // mode selected by a first command byte
   function automatic sspc_mode_t sspc_cmd_mode(input logic [7:0] cmd, input sspc_mode_t m);
      case (cmd)
         SSPC_CMD_QUAD:   sspc_cmd_mode = SSPC_MODE_QUAD;
         SSPC_CMD_DUAL:   sspc_cmd_mode = SSPC_MODE_DUAL;
         SSPC_CMD_SINGLE: sspc_cmd_mode = SSPC_MODE_SINGLE;
         default:         sspc_cmd_mode = m;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: test_serial_sram_pin_control.sv
// self-checking bench joining host and device ends through the pin bundle
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: %h %h", $time, a, b); end end
module test_serial_sram_pin_control
   import sspc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CMDS [3] = '{SSPC_CMD_DUAL, SSPC_CMD_QUAD, SSPC_CMD_SINGLE};
   localparam sspc_mode_t MODES [3] = '{SSPC_MODE_DUAL, SSPC_MODE_QUAD, SSPC_MODE_SINGLE};
   logic       i_mclk = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       req = 1'b0, rd = 1'b0, last = 1'b0, pse = 1'b0, den = 1'b0, busy = 1'b0;
   logic [7:0] tx = 8'h00, dtx = 8'h00, h_rx, d_rx;
   logic       h_ready, h_rv, h_ps, d_rv, d_stb, d_ps, d_cf, d_sel;
   logic       fst = 1'b1;
   sspc_mode_t h_mode, d_mode, m;
   logic [1:0] seen = 2'h0;
   logic [9:0] e;
   logic [9:0] qd[$];
   logic [8:0] qh[$];
   int         err_total = 0, n_compared = 0, seed = 32'h581dbfeb;

   sspc_if bus_if ();
   sspc_host u_sspc_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus_if), .i_req(req),
      .i_tx_byte(tx), .i_read(rd), .i_last(last), .i_pause(pse), .o_ready(h_ready),
      .o_rx_byte(h_rx), .o_rx_valid(h_rv), .o_paused(h_ps), .o_mode(h_mode));
   sspc_dev u_sspc_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(bus_if), .i_tx_byte(dtx),
      .i_tx_en(den), .i_wr_busy(busy), .o_rx_byte(d_rx), .o_rx_valid(d_rv), .o_cmd_first(d_cf),
      .o_tx_take(), .o_selected(d_sel), .o_standby(d_stb), .o_paused(d_ps), .o_mode(d_mode));
   sspc_monitor u_sspc_monitor (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .cs_n(bus_if.cs_n),
      .sck(bus_if.sck), .h_sio_o(bus_if.h_sio_o), .h_sio_oe_n(bus_if.h_sio_oe_n),
      .d_sio_o(bus_if.d_sio_o), .d_sio_oe_n(bus_if.d_sio_oe_n));

   always #25 i_mclk = ~i_mclk;

   // result watcher, oldest note first
   always @(posedge i_mclk) begin
      if (h_ps) seen[1] <= 1'b1;
      if (d_ps) seen[0] <= 1'b1;
      if (d_rv && qd.size() > 0) begin
         e = qd.pop_front();
         `CHK(d_cf, e[9])
         if (e[8]) `CHK(d_rx, e[7:0])
      end
      if (h_rv && qh.size() > 0) begin
         e = {1'b0, qh.pop_front()};
         if (e[8]) `CHK(h_rx, e[7:0])
      end
   end

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic waitr();
      int k;
      k = 0;
      while (h_ready !== 1'b1 && k < 3000) begin
         @(negedge i_mclk);
         k++;
      end
      if (k == 3000) begin
         err_total++;
         test_done();
      end
   endtask

   // one byte through the host, expectations noted first; only a last read is checked
   task automatic xfer(input logic [7:0] b, input logic r, input logic l);
      waitr();
      den = r;
      if (r) qh.push_back({l, dtx});
      qd.push_back({fst, ~r, b});
      fst = l;
      req = 1'b1;
      tx = b;
      rd = r;
      last = l;
      @(negedge i_mclk);
      req = 1'b0;
   endtask

   // command, data with a pause inside except in quad mode, then two reads
   task automatic data_frame();
      logic [7:0] c;
      waitr();
      `CHK(h_mode, m)
      `CHK(d_mode, m)
      c = 8'($random(seed));
      if (c inside {SSPC_CMD_QUAD, SSPC_CMD_DUAL, SSPC_CMD_SINGLE}) c = 8'h03;
      dtx = 8'($random(seed));
      seen = 2'h0;
      xfer(c, 1'b0, 1'b0);
      xfer(8'($random(seed)), 1'b0, 1'b0);
      repeat (20) @(negedge i_mclk);
      pse = 1'b1;
      repeat (40) @(negedge i_mclk);
      pse = 1'b0;
      // dummy read byte turns the lines round before the checked one
      xfer(8'($random(seed)), 1'b1, 1'b0);
      xfer(8'($random(seed)), 1'b1, 1'b1);
      `CHK(seen, {2{m != SSPC_MODE_QUAD}})
      $display("frame done in mode %0d", m);
   endtask

   initial begin
      m = SSPC_MODE_SINGLE;
      repeat (12) @(negedge i_mclk);
      i_rst_n = 1'b1;
      waitr();
      busy = 1'b1;
      repeat (4) @(negedge i_mclk);
      `CHK(d_stb, 1'b0)
      busy = 1'b0;
      repeat (4) @(negedge i_mclk);
      `CHK(d_stb, 1'b1)
      `CHK(d_sel, 1'b0)
      $display("standby test done");
      for (int i = 0; i < 4; i++) begin
         data_frame();
         if (i < 3) begin
            xfer(CMDS[i], 1'b0, 1'b1);
            m = MODES[i];
         end
      end
      waitr();
      `CHK(qd.size() + qh.size() == 0, 1'b1)
      test_done();
   end
endmodule
`default_nettype wire
